// *** rtl/uart_select_latch_baud_out.sv ***
// register select, address strobe latch and baud output of the uart
`timescale 1ns/10ps
`include "uart_front_cfg.svh"
module uart_select_latch_baud_out
    import uart_front_pkg::*;
#(
    parameter int DW = `DIV_WIDTH
) (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic [2:0] register_index_inputs_i,
    input  wire logic       chip_select_high_a_i,
    input  wire logic       chip_select_high_b_i,
    input  wire logic       chip_select_low_n_i,
    input  wire logic       address_strobe_n_i,
    input  wire logic       read_n_i,
    input  wire logic       write_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_n_o,
    output logic      [2:0] selected_index_o,
    output logic            selected_o,
    output logic            tx_rate_clock_out_o,
    output logic            tx_rate_tick_o
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: decision taken when stages two and three agree
    localparam int SW = 9;
    // idle levels: index low, every select and strobe high
    localparam logic [SW-1:0] PIN_REST = `PIN_IDLE;
    logic [SW-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
    logic [SW-1:0] pin_raw;
    assign pin_raw = {register_index_inputs_i, chip_select_high_a_i,
                      chip_select_high_b_i, chip_select_low_n_i,
                      address_strobe_n_i, read_n_i, write_n_i};

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pin_s1_q <= PIN_REST;
            pin_s2_q <= PIN_REST;
            pin_s3_q <= PIN_REST;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_agree
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    pin_q[gi] <= PIN_REST[gi];
                end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                    pin_q[gi] <= pin_s3_q[gi];
                end
            end
        end
    endgenerate

    select_bus_t live_sel;
    strobe_bus_t strobes;
    logic        strobe_n;
    assign live_sel = select_bus_t'(pin_q[8:3]);
    assign strobe_n = pin_q[2];
    assign strobes  = strobe_bus_t'(pin_q[1:0]);

    ////////////////////////////////////////////////////////////////////
    // address strobe latch
    select_bus_t held_q;
    select_bus_t eff_sel;

    // capture on the low-to-high edge, the value present before it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            held_q <= '{default: 1'b0, chip_select_low_n: 1'b1};
        end else if (!strobe_n) begin
            held_q <= live_sel;
        end
    end

    // strobe low: transparent; high: held copy
    assign eff_sel = strobe_n ? held_q : live_sel;

    logic sel_act;
    assign sel_act = eff_sel.chip_select_high_a
                   & eff_sel.chip_select_high_b
                   & ~eff_sel.chip_select_low_n;

    ////////////////////////////////////////////////////////////////////
    // divisor latches and line control, reached by index
    localparam logic [`DIV_WIDTH-1:0] DIV_INIT = `DIV_RESET;
    logic [7:0] div_lo_q;
    logic [7:0] div_hi_q;
    logic [7:0] line_ctrl_q;
    logic       wr_prev_n_q;
    logic       wr_edge;
    logic       wr_div_lo;
    logic       wr_div_hi;
    logic       wr_line_ctrl;
    logic       dlab;
    assign dlab = line_ctrl_q[`DLAB_BIT];

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_prev_n_q <= 1'b1;
        end else begin
            wr_prev_n_q <= strobes.write_n;
        end
    end
    // one write per strobe: act on the falling edge only
    assign wr_edge = wr_prev_n_q & ~strobes.write_n & sel_act;

    ////////////////////////////////////////////////////////////////////
    // write data pins: the strobes' three stages without their agreement stage, so the byte
    // seen at the write edge has settled one clock longer than the strobe
    logic [7:0] data_s1_q;
    logic [7:0] data_s2_q;
    logic [7:0] data_s3_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
            data_s3_q <= 8'h00;
        end else begin
            data_s1_q <= data_i;
            data_s2_q <= data_s1_q;
            data_s3_q <= data_s2_q;
        end
    end

    // divisor latches open only while line control bit 7 is set, so a
    // stray write to index 0 or 1 cannot retune the baud clock
    assign wr_div_lo    = wr_edge & dlab
                        & (eff_sel.register_index == `IDX_DIV_LOW);
    assign wr_div_hi    = wr_edge & dlab
                        & (eff_sel.register_index == `IDX_DIV_HIGH);
    assign wr_line_ctrl = wr_edge
                        & (eff_sel.register_index == `IDX_LINE_CTRL);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            div_lo_q <= DIV_INIT[7:0];
        end else if (wr_div_lo) begin
            div_lo_q <= data_s3_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            div_hi_q <= DIV_INIT[15:8];
        end else if (wr_div_hi) begin
            div_hi_q <= data_s3_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            line_ctrl_q <= `LINE_CTRL_RST;
        end else if (wr_line_ctrl) begin
            line_ctrl_q <= data_s3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path; other indices read zero here
    logic [7:0] rd_d;
    logic [7:0] rd_q;
    logic       reading;
    assign reading = sel_act & ~strobes.read_n;

    always_comb begin
        rd_d = 8'h00;
        case (eff_sel.register_index)
            `IDX_DIV_LOW:   rd_d = dlab ? div_lo_q : 8'h00;
            `IDX_DIV_HIGH:  rd_d = dlab ? div_hi_q : 8'h00;
            `IDX_LINE_CTRL: rd_d = line_ctrl_q;
            default:        rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    logic oe_n_q;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~reading;
        end
    end

    assign data_o           = rd_q;
    assign data_oe_n_o      = oe_n_q;
    assign selected_index_o = eff_sel.register_index;
    assign selected_o       = sel_act;

    ////////////////////////////////////////////////////////////////////
    // baud generator: 16x clock = oscillator / divisor
    rate_divider #(.DW(DW)) u_div (
        .mclk_i     (mclk_i),
        .srst_i     (srst_i),
        .divisor_i  (DW'({div_hi_q, div_lo_q})),
        .tick_o     (tx_rate_tick_o),
        .rate_clk_o (tx_rate_clock_out_o)
    );
endmodule : uart_select_latch_baud_out

// *** rtl/uart_front_cfg.svh ***
// timing counts, divisor layout and reset values for the uart front end
`ifndef UART_FRONT_CFG_SVH
`define UART_FRONT_CFG_SVH
`define DIV_WIDTH     16
`define DIV_RESET     16'h0001
`define IDX_WIDTH     3
`define IDX_DIV_LOW   3'h0
`define IDX_DIV_HIGH  3'h1
`define IDX_LINE_CTRL 3'h3
`define DLAB_BIT      7
`define DATA_WIDTH    8
`define SYNC_STAGES   3
`define PIN_IDLE      9'h03F
`define LINE_CTRL_RST 8'h00
`endif

// *** rtl/uart_front_pkg.sv ***
// types shared by the uart front end
package uart_front_pkg;
    typedef struct packed {
        logic [2:0] register_index;
        logic       chip_select_high_a;
        logic       chip_select_high_b;
        logic       chip_select_low_n;
    } select_bus_t;

    typedef struct packed {
        logic       read_n;
        logic       write_n;
    } strobe_bus_t;
endpackage : uart_front_pkg

// *** rtl/rate_divider.sv ***
// divisor counter that makes the 16x transmit rate clock
`timescale 1ns/10ps
module rate_divider #(
    parameter int DW = 16
) (
    input  wire logic          mclk_i,
    input  wire logic          srst_i,
    input  wire logic [DW-1:0] divisor_i,
    output logic               tick_o,
    output logic               rate_clk_o
);
    logic [DW-1:0] count_q;
    logic          rate_q;
    logic          tick_q;

    // divisor 0 is treated as 1: the output never stalls
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            count_q <= '0;
            tick_q  <= 1'b0;
        end else if (count_q + DW'(1) >= divisor_i) begin
            count_q <= '0;
            tick_q  <= 1'b1;
        end else begin
            count_q <= count_q + DW'(1);
            tick_q  <= 1'b0;
        end
    end

    // low for the first half of the period: frequency is mclk / divisor
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rate_q <= 1'b0;
        end else begin
            rate_q <= (count_q >= (divisor_i >> 1)) && (divisor_i > DW'(1));
        end
    end

    assign tick_o     = tick_q;
    assign rate_clk_o = (divisor_i <= DW'(1)) ? tick_q : rate_q;
endmodule : rate_divider

// *** bench/uart_front_chk.sv ***
// port assertions for the uart front end
`timescale 1ns/10ps
module uart_front_chk (
    input wire logic       mclk_i,
    input wire logic       srst_i,
    input wire logic [2:0] register_index_inputs_i,
    input wire logic       chip_select_high_a_i,
    input wire logic       chip_select_high_b_i,
    input wire logic       chip_select_low_n_i,
    input wire logic       address_strobe_n_i,
    input wire logic       read_n_i,
    input wire logic [2:0] selected_index_o,
    input wire logic       selected_o,
    input wire logic       data_oe_n_o,
    input wire logic       tx_rate_tick_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // cycles since the last tick, bounded by the largest divisor
    logic [16:0] gap_q;
    always_ff @(posedge mclk_i) begin
        gap_q <= (srst_i || tx_rate_tick_o) ? 17'h00000 : gap_q + 17'h00001;
    end
    property p_pass;
        (!address_strobe_n_i && $stable(register_index_inputs_i))[*6]
        |-> selected_index_o == register_index_inputs_i;
    endproperty
    a_pass: assert property (p_pass) else $error("index not passed");
    property p_hold;
        address_strobe_n_i[*6] |=> $stable(selected_index_o) && $stable(selected_o);
    endproperty
    a_hold: assert property (p_hold) else $error("select not held");
    property p_desel;
        (!address_strobe_n_i && !chip_select_high_a_i)[*6] |-> !selected_o;
    endproperty
    a_desel: assert property (p_desel) else $error("wrongly selected");
    property p_sel;
        (!address_strobe_n_i && chip_select_high_a_i && chip_select_high_b_i
         && !chip_select_low_n_i)[*6] |-> selected_o;
    endproperty
    a_sel: assert property (p_sel) else $error("not selected");
    property p_oe;
        !$past(selected_o) |-> data_oe_n_o;
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven idle");
    property p_rd;
        (selected_o && !read_n_i)[*6] |-> !data_oe_n_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_gap;
        gap_q < 17'h10000;
    endproperty
    a_gap: assert property (p_gap) else $error("tick missing");
endmodule : uart_front_chk
bind uart_select_latch_baud_out uart_front_chk chk_inst (.mclk_i, .srst_i,
    .register_index_inputs_i, .chip_select_high_a_i, .chip_select_high_b_i,
    .chip_select_low_n_i, .address_strobe_n_i, .read_n_i, .selected_index_o,
    .selected_o, .data_oe_n_o, .tx_rate_tick_o);

// *** bench/host_bus.sv ***
// host processor model on the uart pins
`timescale 1ns/10ps
module host_bus (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       oe_n_i,
    output logic      [2:0] idx_o,
    output logic      [2:0] cs_o,
    output logic            as_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic      [7:0] bus_o
);
    logic [7:0] hd = 8'h00;
    logic       hoe = 1'b0;
    // a released bus shows the inverted last value, never a held copy
    assign bus_o = !oe_n_i ? rdata_i : hoe ? hd : ~hd;
    initial {idx_o, cs_o, as_n_o, rd_n_o, wr_n_o} = 9'h00B;
    task automatic sel(input logic [5:0] v, input logic as_n);
        @(negedge mclk_i);
        {idx_o, cs_o} = v;
        as_n_o = as_n;
        repeat (8) @(negedge mclk_i);
    endtask : sel
    task automatic acc(input logic [2:0] i, input logic w,
                       input logic [7:0] d, output logic [8:0] q);
        sel({i, 3'h6}, 1'b0);
        hd = d;
        hoe = w;
        if (w) wr_n_o = 1'b0;
        else rd_n_o = 1'b0;
        repeat (8) @(negedge mclk_i);
        q = {oe_n_i, rdata_i};
        {rd_n_o, wr_n_o} = 2'h3;
        repeat (8) @(negedge mclk_i);
        hoe = 1'b0;
        sel({i, 3'h1}, 1'b0);
    endtask : acc
endmodule : host_bus

// *** bench/testbench.sv ***
// self-checking bench for the uart select latch and baud output
`timescale 1ns/10ps
module testbench;
    logic       mclk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic [2:0] idx, cs, sidx;
    logic       as_n, rd_n, wr_n, oe_n, sel_o, tick, baud;
    logic       baud_prev = 1'b0;
    int         baud_cnt = 0, baud_gap = 0;
    logic [7:0] bus, dout, dv [3];
    logic [8:0] q;
    logic [5:0] v;
    int         n_mismatch = 0, checks_done = 0, seed = 84684, g;
    initial forever #12.5 mclk_i = ~mclk_i;
    // period of the baud output, in clocks between rising edges
    always @(negedge mclk_i) begin
        baud_prev <= baud;
        if (baud && !baud_prev) begin
            baud_gap <= baud_cnt;
            baud_cnt <= 1;
        end else begin
            baud_cnt <= baud_cnt + 1;
        end
    end
    host_bus host_bus_inst (.mclk_i, .rdata_i(dout), .oe_n_i(oe_n),
        .idx_o(idx), .cs_o(cs), .as_n_o(as_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .bus_o(bus));
    uart_select_latch_baud_out uart_select_latch_baud_out_inst (.mclk_i,
        .srst_i, .register_index_inputs_i(idx), .chip_select_high_a_i(cs[2]),
        .chip_select_high_b_i(cs[1]), .chip_select_low_n_i(cs[0]),
        .address_strobe_n_i(as_n), .read_n_i(rd_n), .write_n_i(wr_n),
        .data_i(bus), .data_o(dout), .data_oe_n_o(oe_n),
        .selected_index_o(sidx), .selected_o(sel_o),
        .tx_rate_clock_out_o(baud), .tx_rate_tick_o(tick));
    task automatic chk(input string nm, input logic [7:0] e, s);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    function automatic logic exp_sel(input logic [2:0] c);
        return c == 3'h6;
    endfunction : exp_sel
    task automatic tick_gap(output int n);
        n = 0;
        do begin @(negedge mclk_i); n++; end while (tick !== 1'b1 && n < 99);
    endtask : tick_gap
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(negedge mclk_i);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (6) @(negedge mclk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        for (int k = 0; k < 12; k++) begin
            v = 6'($random(seed));
            if (k < 2) v[2:0] = 3'h6;
            host_bus_inst.sel(v, 1'b0);
            chk("sel", 8'(exp_sel(v[2:0])), 8'(sel_o));
            if (exp_sel(v[2:0])) chk("idx", 8'(v[5:3]), 8'(sidx));
        end
        host_bus_inst.sel(6'h2E, 1'b0);
        host_bus_inst.sel(6'h2E, 1'b1);
        host_bus_inst.sel(6'h11, 1'b1);
        chk("held_idx", 8'h05, 8'(sidx));
        chk("held_sel", 8'h01, 8'(sel_o));
        host_bus_inst.sel(6'h11, 1'b0);
        chk("pass_sel", 8'h00, 8'(sel_o));
        chk("pass_idx", 8'h02, 8'(sidx));
        dv = '{8'h01, 8'h02, 8'($random(seed)) & 8'h0F | 8'h03};
        foreach (dv[j]) begin
            host_bus_inst.acc(3'h3, 1'b1, 8'h80, q);
            host_bus_inst.acc(3'h0, 1'b1, dv[j], q);
            host_bus_inst.acc(3'h1, 1'b1, 8'h00, q);
            host_bus_inst.acc(3'h3, 1'b1, 8'h03, q);
            tick_gap(g);
            tick_gap(g);
            chk("tick_gap", dv[j], 8'(g));
            if (dv[j] > 8'h01)
                chk("baud_gap", dv[j], 8'(baud_gap));
            else
                chk("baud_high", 8'h01, 8'(baud));
        end
        host_bus_inst.acc(3'h3, 1'b0, 8'h00, q);
        chk("read", 8'h03, q[7:0]);
        chk("oe_read", 8'h00, 8'(q[8]));
        chk("oe_idle", 8'h01, 8'(oe_n));
        host_bus_inst.acc(3'h0, 1'b1, 8'hAA, q);
        host_bus_inst.acc(3'h0, 1'b0, 8'h00, q);
        chk("div_closed", 8'h00, q[7:0]);
        host_bus_inst.acc(3'h3, 1'b1, 8'h83, q);
        host_bus_inst.acc(3'h0, 1'b0, 8'h00, q);
        chk("div_low", dv[2], q[7:0]);
        host_bus_inst.acc(3'h1, 1'b0, 8'h00, q);
        chk("div_high", 8'h00, q[7:0]);
        repeat (2) @(negedge mclk_i);
        srst_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        chk("rst_oe", 8'h01, 8'(oe_n));
        tick_gap(g);
        tick_gap(g);
        chk("rst_div", 8'h01, 8'(g));
        close_out();
    end
endmodule : testbench
